// ### pkg/apo_pkg.sv
/*
 * Constants for the converter parallel output port.
 * Assumes a single 125 MHz system clock and a synchronous active-low reset.
 */
// Behaviour
// [RULE1] Capture side holds logic inputs low at power-up
// [RULE2] All sequencing on rising clock edges only
// [RULE3] One new result every two clocks
// [RULE4] Result is straight binary, bit 0 LSB
// [RULE5] Result and flag updated on rising edge
// [RULE6] Enable high floats outputs, low drives them
// [RULE7] Flag set when input exceeds full scale
// [RULE8] Flag set forces all result bits high
// [RULE9] Result appears twelve clocks after sampling
// [RULE10] Eight sections rotate, schedule repeats every sixteen
// [RULE11] Capture side gives 10000 clocks before calibrated use
// [RULE12] Strobe marks each new word once
// [RULE13] Tri-state never disturbs conversion sequence
package apo_pkg;
	localparam int           RES_W         = 10;
	localparam int           NUM_SECTIONS  = 8;
	localparam int           SAMPLE_PERIOD = 2;
	localparam int           SCHED_LEN     = 16;
	localparam int           LATENCY       = 12;
	localparam int           CAL_CYCLES    = 10000;
	localparam int           SAMPLE_W      = 11;
	localparam logic [9:0]   RES_FULL      = 10'h3FF;
	localparam logic [9:0]   RES_ZERO      = 10'h000;
	localparam logic [10:0]  SAMPLE_ZERO   = 11'h000;
	localparam logic [3:0]   PHASE_RESET   = 4'h0;
	localparam logic [7:0]   SECT_RESET    = 8'h01;
endpackage : apo_pkg

// ### rtl/apo_buffer.sv
/*
 * Two-entry valid/ready buffer carrying one result word plus flag.
 * Assumes both sides run on the same clock.
 */
`timescale 1ns/1ps
module apo_buffer #(
	parameter int WIDTH = 11
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             reset_n_in,
	// Fill side
	input  wire logic             s_valid_in,
	output      logic             s_ready_out,
	input  wire logic [WIDTH-1:0] s_data_in,
	// Drain side
	output      logic             m_valid_out,
	input  wire logic             m_ready_in,
	output      logic [WIDTH-1:0] m_data_out
);
	logic [WIDTH-1:0] mem_q [2];
	logic             wr_ptr_q;
	logic             rd_ptr_q;
	logic [1:0]       count_q;
	logic             push;
	logic             pop;

	assign s_ready_out = (count_q != 2'h2);
	assign m_valid_out = (count_q != 2'h0);
	assign m_data_out  = mem_q[rd_ptr_q];
	assign push        = s_valid_in && s_ready_out;
	assign pop         = m_valid_out && m_ready_in;

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_ptr_q] <= s_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q  <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // apo_buffer

// ### rtl/apo_port.sv
/*
 * Digital output side of a 10-bit time-interleaved converter.
 * Samples arrive each cycle as a quantised code from the front end; the
 * block picks one every second clock, rotates it through eight sections,
 * and presents it twelve clocks later with an over-range flag and strobe.
 * Assumes the analog front end delivers an 11-bit unsigned level on the
 * system clock, where codes above full scale mean over-range.
 */
`timescale 1ns/1ps
module apo_port
	import apo_pkg::*;
(
	// Clock and reset
	input  wire logic                        CLK_SYS_IN,
	input  wire logic                        RESET_N_IN,
	// Front end sample and output enable pin
	input  wire logic [apo_pkg::SAMPLE_W-1:0] SAMPLE_LEVEL_IN,
	input  wire logic                        OUT_EN_N_IN,
	// Result pins
	output      logic [apo_pkg::RES_W-1:0]   CONV_RESULT_BITS_OUT,
	output      logic [apo_pkg::RES_W-1:0]   CONV_RESULT_BITS_OE_OUT,
	output      logic                        RANGE_EXCEEDED_FLAG_OUT,
	output      logic                        RANGE_EXCEEDED_FLAG_OE_OUT,
	output      logic                        RESULT_STROBE_OUT,
	// Capture side back-pressure and calibration status
	input  wire logic                        CAPTURE_READY_IN,
	output      logic                        CAL_DONE_OUT
);
	import apo_pkg::*;

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	logic [SAMPLE_W-1:0] lvl_meta_q;
	logic [SAMPLE_W-1:0] lvl_sync_q;
	logic                en_meta_q;
	logic                en_sync_q;

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			lvl_meta_q <= SAMPLE_ZERO;
			lvl_sync_q <= SAMPLE_ZERO;
			en_meta_q  <= 1'b1;
			en_sync_q  <= 1'b1;
		end else begin
			lvl_meta_q <= SAMPLE_LEVEL_IN;
			lvl_sync_q <= lvl_meta_q;
			en_meta_q  <= OUT_EN_N_IN;
			en_sync_q  <= en_meta_q;
		end
	end

	// ---------------------------------------------------------------
	// Sixteen-phase schedule
	// ---------------------------------------------------------------
	// Runs regardless of output enable so tri-state never slips a sample
	logic [3:0] phase_q;
	logic [7:0] sect_q;
	logic       sample_en;

	assign sample_en = (phase_q[0] == 1'b0); // [RULE3]

	always_ff @(posedge CLK_SYS_IN) begin // [RULE2]
		if (!RESET_N_IN) begin
			phase_q <= PHASE_RESET;
			sect_q  <= SECT_RESET;
		end else begin
			phase_q <= phase_q + 4'h1; // [RULE10] [RULE13]
			if (phase_q[0]) begin
				sect_q <= {sect_q[6:0], sect_q[7]}; // [RULE10]
			end
		end
	end

	// ---------------------------------------------------------------
	// Per-section capture and conversion pipeline
	// ---------------------------------------------------------------
	function automatic logic [RES_W:0] encode(input logic [SAMPLE_W-1:0] lvl);
		logic over;
		over = (lvl > {1'b0, RES_FULL});
		encode = {over, over ? RES_FULL : lvl[RES_W-1:0]}; // [RULE4] [RULE7] [RULE8]
	endfunction

	logic [RES_W:0] sect_word_q [NUM_SECTIONS];
	logic [RES_W:0] pipe_q [LATENCY-1];
	logic           vld_q [LATENCY-1];
	logic [RES_W:0] sect_pick;

	// Word held by the section that sampled last, for the rotation check
	always_comb begin
		sect_pick = '0;
		for (int i = 0; i < NUM_SECTIONS; i++) begin
			if (sect_q[i]) begin
				sect_pick = sect_pick | sect_word_q[i];
			end
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		for (int i = 0; i < NUM_SECTIONS; i++) begin
			if (sample_en && sect_q[i]) begin
				sect_word_q[i] <= encode(lvl_sync_q);
			end
		end
	end

	// Pipeline carries the word from its sampling edge to the buffer input
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			for (int i = 0; i < LATENCY-1; i++) begin
				pipe_q[i] <= '0;
				vld_q[i]  <= 1'b0;
			end
		end else begin
			pipe_q[0] <= encode(lvl_sync_q);
			vld_q[0]  <= sample_en;
			for (int i = 1; i < LATENCY-1; i++) begin
				pipe_q[i] <= pipe_q[i-1]; // [RULE9]
				vld_q[i]  <= vld_q[i-1];
			end
		end
	end

	// ---------------------------------------------------------------
	// Two-entry buffer toward the pins
	// ---------------------------------------------------------------
	logic           buf_in_ready;
	logic           buf_valid;
	logic [RES_W:0] buf_data;
	logic           take;

	apo_buffer #(.WIDTH(RES_W+1)) u_buf (
		.clk_in      (CLK_SYS_IN),
		.reset_n_in  (RESET_N_IN),
		.s_valid_in  (vld_q[LATENCY-2]),
		.s_ready_out (buf_in_ready),
		.s_data_in   (pipe_q[LATENCY-2]),
		.m_valid_out (buf_valid),
		.m_ready_in  (CAPTURE_READY_IN),
		.m_data_out  (buf_data)
	);

	assign take = buf_valid && CAPTURE_READY_IN;

	// ---------------------------------------------------------------
	// Output latches and enables
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			CONV_RESULT_BITS_OUT    <= RES_ZERO;
			RANGE_EXCEEDED_FLAG_OUT <= 1'b0;
			RESULT_STROBE_OUT       <= 1'b0;
		end else begin
			RESULT_STROBE_OUT <= take; // [RULE12]
			if (take) begin
				CONV_RESULT_BITS_OUT    <= buf_data[RES_W-1:0]; // [RULE5]
				RANGE_EXCEEDED_FLAG_OUT <= buf_data[RES_W]; // [RULE5]
			end
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			CONV_RESULT_BITS_OE_OUT    <= RES_ZERO;
			RANGE_EXCEEDED_FLAG_OE_OUT <= 1'b0;
		end else begin
			CONV_RESULT_BITS_OE_OUT    <= {RES_W{~en_sync_q}}; // [RULE6]
			RANGE_EXCEEDED_FLAG_OE_OUT <= ~en_sync_q; // [RULE6]
		end
	end

	// ---------------------------------------------------------------
	// Calibration settle counter
	// ---------------------------------------------------------------
	// Informs capture logic; results before this are uncalibrated
	logic [13:0] cal_cnt_q;

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			cal_cnt_q    <= 14'h0000;
			CAL_DONE_OUT <= 1'b0;
		end else if (cal_cnt_q != 14'(CAL_CYCLES)) begin
			cal_cnt_q <= cal_cnt_q + 14'h0001; // [RULE11]
		end else begin
			CAL_DONE_OUT <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_SAMPLE_EVERY_TWO: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // [RULE3]
		vld_q[0] |=> !vld_q[0] ##1 vld_q[0])
		else $error("Sample cadence is not one per two clocks");

	AST_PHASE_WRAP: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // [RULE10]
		(phase_q == 4'hF) |=> (phase_q == 4'h0) && $stable(sect_q) == 1'b0)
		else $error("Schedule does not repeat every sixteen clocks");

	AST_ONE_SECTION: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // [RULE10]
		$onehot(sect_q))
		else $error("More than one section selected");

	AST_LATENCY: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // [RULE9]
		vld_q[0] |-> ##(10) (vld_q[10] && pipe_q[10] == $past(pipe_q[0], 10)))
		else $error("Pipeline latency is wrong");

	AST_SATURATE: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // [RULE8]
		RANGE_EXCEEDED_FLAG_OUT |-> CONV_RESULT_BITS_OUT == RES_FULL)
		else $error("Over-range word is not saturated");

	AST_FLAG_CAUSE: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // [RULE7]
		vld_q[0] |-> pipe_q[0][RES_W] == ($past(lvl_sync_q) > {1'b0, RES_FULL}))
		else $error("Over-range flag disagrees with level");

	AST_CODE: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // [RULE4]
		(vld_q[0] && !pipe_q[0][RES_W]) |-> pipe_q[0][RES_W-1:0] == $past(lvl_sync_q[RES_W-1:0]))
		else $error("Result is not straight binary");

	AST_TRISTATE: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // [RULE6]
		$past(en_sync_q) |-> CONV_RESULT_BITS_OE_OUT == RES_ZERO && !RANGE_EXCEEDED_FLAG_OE_OUT)
		else $error("Outputs driven while enable is high");

	AST_STROBE_DATA: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // [RULE12]
		RESULT_STROBE_OUT |-> {RANGE_EXCEEDED_FLAG_OUT, CONV_RESULT_BITS_OUT} == $past(buf_data))
		else $error("Strobe without matching word");

	AST_NO_STALL: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // [RULE13]
		en_sync_q |=> phase_q == $past(phase_q) + 4'h1)
		else $error("Schedule stalled under tri-state");

	AST_SECTION_WORD: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // [RULE10]
		vld_q[0] |-> sect_pick == pipe_q[0])
		else $error("Sampling section holds a different word");

	AST_BUF_ACCEPT: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // [RULE12]
		($past(CAPTURE_READY_IN) && vld_q[LATENCY-2]) |-> buf_in_ready)
		else $error("Buffer refused a word while capture side was ready");
endmodule // apo_port

// ### sim/apo_capture_model.sv
/*
 * Capture logic model standing on the far side of the result pins.
 * Assumes the bench clock and a stall request from the bench.
 */
`timescale 1ns/1ps
module apo_capture_model
	import apo_pkg::*;
(
	// Clock and control
	input  wire logic                      clk_in,
	input  wire logic                      stall_in,
	// Result pins
	input  wire logic                      strobe_in,
	input  wire logic [apo_pkg::RES_W-1:0] bits_in,
	input  wire logic [apo_pkg::RES_W-1:0] bits_oe_in,
	input  wire logic                      flag_in,
	input  wire logic                      flag_oe_in,
	// Capture side
	output      logic                      ready_out,
	output      logic [apo_pkg::RES_W:0]   word_out
);
	logic [RES_W-1:0] bits_seen;
	logic             flag_seen;
	logic [RES_W:0]   word_q = '0;

	// Floated lines read as the inverse of the last word, never a stale copy
	assign bits_seen = (bits_in & bits_oe_in) | (~word_out[RES_W-1:0] & ~bits_oe_in);
	assign flag_seen = flag_oe_in ? flag_in : ~word_out[RES_W];
	assign ready_out = ~stall_in;

	assign word_out  = word_q;

	// Flag and bits latched together as one unit
	always @(posedge clk_in) begin
		if (strobe_in === 1'b1)
			word_q <= {flag_seen, bits_seen};
	end
endmodule // apo_capture_model

// ### sim/apo_port_bench.sv
/*
 * Self-checking bench for the converter output port.
 * Assumes the capture model drives the ready input.
 */
`timescale 1ns/1ps
module apo_port_bench;
	import apo_pkg::*;
	// Starts low without an edge so reset spans exactly twenty rising edges
	logic                clk = 1'b0;
	logic                rst_n, out_en_n, stall;
	logic [SAMPLE_W-1:0] level;
	wire  [RES_W-1:0]    bits, bits_oe;
	wire                 flag, flag_oe, strobe, ready, cal_done;
	wire  [RES_W:0]      word;
	int                  n_fail, comparisons, n_strb, n0, k;
	logic [SAMPLE_W-1:0] codes [9] = '{11'h000, 11'h001, 11'h155, 11'h200, 11'h3FE, 11'h3FF, 11'h400, 11'h401, 11'h7FF};

	apo_port DUT (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .SAMPLE_LEVEL_IN(level), .OUT_EN_N_IN(out_en_n),
		.CONV_RESULT_BITS_OUT(bits), .CONV_RESULT_BITS_OE_OUT(bits_oe), .RANGE_EXCEEDED_FLAG_OUT(flag),
		.RANGE_EXCEEDED_FLAG_OE_OUT(flag_oe), .RESULT_STROBE_OUT(strobe), .CAPTURE_READY_IN(ready),
		.CAL_DONE_OUT(cal_done));
	apo_capture_model capture (.clk_in(clk), .stall_in(stall), .strobe_in(strobe), .bits_in(bits),
		.bits_oe_in(bits_oe), .flag_in(flag), .flag_oe_in(flag_oe), .ready_out(ready), .word_out(word));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		if (strobe === 1'b1)
			n_strb++;
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_codes;
		logic [RES_W:0] exp;
		foreach (codes[i]) begin
			level = codes[i];
			cyc(40);
			exp = (codes[i] > 11'h3FF) ? {1'b1, RES_FULL} : {1'b0, codes[i][RES_W-1:0]};
			check("word", word, exp);
		end
	endtask
	task automatic t_rate;
		n0 = n_strb;
		cyc(64);
		check("strobes", n_strb - n0, 32);
	endtask
	task automatic t_latency;
		level = 11'h000;
		cyc(40);
		level = 11'h2AA;
		k = 0;
		while (word[RES_W-1:0] !== 10'h2AA && k < 40) begin
			cyc(1);
			k++;
		end
		// Two sync flops, the sampling edge, up to one slot wait, twelve clocks, one capture latch
		check("latency", (k >= LATENCY + 4 && k <= LATENCY + 5), 1);
	endtask
	task automatic t_tristate;
		out_en_n = 1'b1;
		level = 11'h123;
		n0 = n_strb;
		cyc(32);
		check("bits_oe off", bits_oe, 10'h000);
		check("flag_oe off", flag_oe, 1'b0);
		check("strobes floated", n_strb - n0, 16);
		out_en_n = 1'b0;
		cyc(8);
		check("bits_oe on", bits_oe, 10'h3FF);
		check("flag_oe on", flag_oe, 1'b1);
		check("word after float", word, 11'h123);
	endtask
	task automatic t_stall;
		level = 11'h0F0;
		cyc(40);
		stall = 1'b1;
		// A strobe launched before the stall may still be out
		cyc(1);
		n0 = n_strb;
		cyc(16);
		check("strobes stalled", n_strb - n0, 0);
		level = 11'h0F1;
		stall = 1'b0;
		cyc(40);
		check("word after stall", word, 11'h0F1);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		rst_n = 1'b0;
		out_en_n = 1'b0;
		level = '0;
		stall = 1'b1;
		cyc(20);
		check("strobe in reset", strobe, 1'b0);
		check("oe in reset", bits_oe, 10'h000);
		rst_n = 1'b1;
		stall = 1'b0;
		cyc(1);
		check("cal early", cal_done, 1'b0);
		t_codes();
		t_rate();
		t_latency();
		t_tristate();
		t_stall();
		cyc(CAL_CYCLES);
		check("cal done", cal_done, 1'b1);
		close_out();
	end
	initial begin
		#(8 * 30000);
		n_fail++;
		close_out();
	end
endmodule // apo_port_bench
